// [verif/dioc_contacts.sv]
// Purpose: contact devices on the far side of the discrete pins
// Assumes: close_cmd bit 0 is the object detector, bits 2:1 the input modules
// Notes: 1 = contact closed; contacts settle on a clock edge, no bounce
module dioc_contacts (
	input wire logic clk_sys,
	input wire logic [2:0] close_cmd,
	output logic pkg_detect_in,
	output logic [1:0] disc_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// contact state follows the command one edge later
	always_ff @(posedge clk_sys)
	begin
		pkg_detect_in <= close_cmd[0];
		disc_in <= close_cmd[2:1];
	end
endmodule

// [verif/dioc_top_sva.sv]
// Purpose: port checks for the discrete conditioner
// Assumes: zero wait APB slave
// Notes: attached by bind below
module dioc_top_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pkg_detect_in,
	input wire logic [1:0] disc_in,
	input wire logic [1:0] relay_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// access phase qualifier
	wire acc = psel & penable;
	sequence s_release;
		$fell(reset);
	endsequence
	sequence s_idle2;
		relay_out == 2'b00 ##1 relay_out == 2'b00;
	endsequence
	ready_always_a: assert property (acc |-> pready) else $error("pready low");
	unmapped_err_a: assert property (acc && paddr > 12'h110 |-> pslverr)
		else $error("no error on unmapped");
	misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("no error on misaligned");
	err_access_a: assert property (!acc |-> !pslverr) else $error("error outside access");
	err_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read not zero");
	status_ok_a: assert property (acc && paddr == 12'h110 |-> !pslverr)
		else $error("status refused");
	status_relay_a: assert property (acc && !pwrite && paddr == 12'h110 |-> prdata[7:6] == relay_out)
		else $error("status relay mismatch");
	reset_idle_a: assert property (s_release |-> s_idle2)
		else $error("relay active after reset");
endmodule
bind dioc_top dioc_top_sva i_sva (.clk_sys(clk_sys), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pkg_detect_in(pkg_detect_in),
	.disc_in(disc_in), .relay_out(relay_out));

// [verif/test_discrete_io_conditioner.sv]
// Purpose: self-checking bench for the discrete conditioner
// Assumes: most times left at zero; one scenario waits across a single ms tick
// Notes: 16 clock settle covers the channel pipeline
module test_discrete_io_conditioner;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, pkg_detect_in, e;
	logic [1:0] disc_in, relay_out;
	logic [2:0] cmd = 0;
	int n_mismatch = 0, cmp_count = 0;
	initial forever #12.5 clk_sys = ~clk_sys;
	dioc_top i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pkg_detect_in(pkg_detect_in), .disc_in(disc_in),
		.relay_out(relay_out));
	dioc_contacts i_contacts (.clk_sys(clk_sys), .close_cmd(cmd),
		.pkg_detect_in(pkg_detect_in), .disc_in(disc_in));
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	// one apb transfer; released only after pready is sampled
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task st;
		repeat (16) @(posedge clk_sys);
		apb(0, dioc_pkg::STATUS, 0);
	endtask
	task end_sim;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_refused;
		apb(0, 12'h200, 0);
		chk("unmapped err", {31'h0, e}, 1);
		chk("unmapped data", r, 0);
		apb(1, 12'h002, 32'hffff_ffff);
		chk("misaligned err", {31'h0, e}, 1);
		apb(0, 12'h000, 0);
		chk("refused write", r, dioc_pkg::CF_RST);
	endtask
	task t_polarity;
		cmd <= 3'b001;
		st;
		chk("high closed", {31'h0, r[0]}, 1);
		apb(1, 12'h000, 0);
		st;
		chk("low closed", {31'h0, r[0]}, 0);
		cmd <= 3'b000;
		st;
		chk("low open", {31'h0, r[0]}, 1);
		apb(1, 12'h000, dioc_pkg::CF_RST);
		for (int c = 1; c < 3; c++)
		begin
			cmd <= 3'(1 << c);
			st;
			chk("disc on", {30'h0, r[2:1]}, 32'(c));
		end
	endtask
	// both relays, both idle states, trigger tracking
	task t_outputs;
		for (int o = 0; o < 2; o++)
			for (int nc = 0; nc < 2; nc++)
			begin
				apb(1, 12'(12'h100 + 4 * o), 32'((nc << 15) | ((o + 1) << 16)));
				cmd <= 0;
				st;
				chk("relay idle", {31'h0, relay_out[o]}, 32'(nc));
				chk("status relay", {31'h0, r[6 + o]}, 32'(nc));
				cmd <= 3'(2 << o);
				st;
				chk("relay active", {31'h0, relay_out[o]}, 32'(1 - nc));
			end
	endtask
	task t_input_timer;
		apb(1, 12'h060, 32'h0000_0061);
		apb(1, 12'h080, 32'h0000_0071);
		cmd <= 3'b011;
		st;
		chk("timers on", {30'h0, r[4:3]}, 3);
		repeat (200) @(posedge clk_sys);
		apb(0, dioc_pkg::STATUS, 0);
		chk("timers hold", {30'h0, r[4:3]}, 3);
		cmd <= 3'b000;
		st;
		chk("timers off", {30'h0, r[4:3]}, 0);
	endtask
	task t_mid_reset;
		cmd <= 3'b010;
		@(posedge clk_sys);
		reset <= 1;
		repeat (2) @(posedge clk_sys);
		chk("relay in reset", {30'h0, relay_out}, 0);
		reset <= 0;
		apb(0, 12'h060, 0);
		chk("cfg after reset", r, dioc_pkg::CF_RST);
	endtask
	// runs right after a reset so the first ms tick is ~40000 clocks away
	task t_timed;
		apb(1, 12'h008, 32'h0000_0001);
		apb(1, 12'h02C, 32'h0000_0001);
		apb(1, 12'h044, 32'h0000_0001);
		apb(1, 12'h100, 32'h0006_0001);
		apb(1, dioc_pkg::TMR_ON, 32'h0000_0002);
		apb(1, dioc_pkg::TMR_OFF, 32'h0000_0001);
		cmd <= 3'b111;
		repeat (4) @(posedge clk_sys);
		cmd <= 3'b110;
		st;
		chk("min stretch", {31'h0, r[0]}, 1);
		chk("max before", {31'h0, r[1]}, 1);
		chk("delay hold", {31'h0, r[2]}, 0);
		chk("timer off", {31'h0, r[5]}, 0);
		chk("out on time", {31'h0, relay_out[0]}, 1);
		repeat (40100) @(posedge clk_sys);
		apb(0, dioc_pkg::STATUS, 0);
		chk("min ended", {31'h0, r[0]}, 0);
		chk("max cut", {31'h0, r[1]}, 0);
		chk("delay done", {31'h0, r[2]}, 1);
		chk("timer on", {31'h0, r[5]}, 1);
		chk("out timed off", {31'h0, relay_out[0]}, 0);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		reset <= 0;
		apb(0, dioc_pkg::CH_BASE, 0);
		chk("cfg reset", r, dioc_pkg::CF_RST);
		st;
		chk("status reset", r & 32'h0000_00ff, 0);
		t_refused;
		t_polarity;
		t_outputs;
		t_input_timer;
		t_mid_reset;
		t_timed;
		end_sim;
	end
	// watchdog beyond the one ms tick wait plus the short scenarios
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		end_sim;
	end
endmodule

// [verilog/dioc_pkg.sv]
// Purpose: constants shared by the discrete I/O conditioner
// Assumes: 40 MHz system clock, APB register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package dioc_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned DEB_MS = 15;
	localparam logic [14:0] DEB_TICKS = 15'(DEB_MS);
	localparam int unsigned TW = 15;
	// channel config word: [0] polarity high, [1] debounce, [2] cyclic enable
	localparam int unsigned CF_POL = 0;
	localparam int unsigned CF_DEB = 1;
	localparam int unsigned CF_CYC = 2;
	localparam int unsigned CF_SRC = 4;
	localparam logic [31:0] CF_RST = 32'h0000_0001;
	// channel block: 0 object detect, 1..2 input modules, 3..4 input timers; 8 words each
	localparam int unsigned NCH = 5;
	localparam logic [11:0] CH_BASE = 12'h000;
	localparam logic [11:0] CH_STRIDE = 12'h020;
	localparam logic [2:0] W_CFG = 3'h0;
	localparam logic [2:0] W_DLY = 3'h1;
	localparam logic [2:0] W_MIN = 3'h2;
	localparam logic [2:0] W_MAX = 3'h3;
	localparam logic [2:0] W_CON = 3'h4;
	localparam logic [2:0] W_COFF = 3'h5;
	localparam logic [11:0] OUT0_CFG = 12'h100;
	localparam logic [11:0] OUT1_CFG = 12'h104;
	localparam logic [11:0] TMR_ON = 12'h108;
	localparam logic [11:0] TMR_OFF = 12'h10C;
	localparam logic [11:0] STATUS = 12'h110;
	// output config: [14:0] on time, [15] normally closed, [18:16] trigger select
	localparam int unsigned OC_NC = 15;
	localparam int unsigned OC_SEL = 16;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
endpackage

// [verilog/dioc_top.sv]
// Purpose: discrete input conditioning, output contacts and cyclic timer
// Assumes: pins synchronous to clk_sys; APB slave, zero wait states
// Notes: channels 0..2 are pin inputs, 3..4 are input timers with a selected trigger
//
// Contract
// - each input has a polarity: high means closed contact on, low means open.
// - optional debounce ignores any level change lasting under 15 ms.
// - input timings are millisecond counts from 0 to 32767.
// - after a raw change the old state is held for the on/off delay.
// - an active pulse shorter than the minimum is stretched to the minimum.
// - an active pulse longer than the maximum is cut at the maximum.
// - cyclic mode alternates on time and off time while input is active.
// - cyclic on and off times are 0 to 32767 ms each.
// - outputs have idle state open or closed, driving the opposite when active.
// - a triggered output stays active for its on time, 0 to 32767 ms.
// - output on time zero makes the output follow its trigger exactly.
// - the free running timer stays on for its programmed on time.
// - then stays off for its off time, repeating forever.
// - two input timers use the same chain but take a selected trigger.
// - input timer cycles only while trigger active; else simply stays off.
module dioc_top (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pkg_detect_in,
	input wire logic [1:0] disc_in,
	output logic [1:0] relay_out
);
	// limit stage states, gray coded along idle, min, run, hold
	typedef enum logic [1:0] {DIOC_IDLE = 2'b00, DIOC_MIN = 2'b01, DIOC_RUN = 2'b11,
		DIOC_HOLD = 2'b10} dioc_lim_t;

	////////////////////////////////////////////////////////////////////////////
	// millisecond tick
	// one shared prescaler keeps every channel on the same ms grid;
	// counts are quantised to it, so a timing may end up to 1 ms early
	logic [15:0] pre_q;
	logic tick_q;
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			pre_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= (pre_q == 16'(dioc_pkg::TICK_CYC - 1));
			pre_q <= (pre_q == 16'(dioc_pkg::TICK_CYC - 1)) ? 16'h0000 : pre_q + 16'h0001;
		end

	////////////////////////////////////////////////////////////////////////////
	// register file
	// channel words: 0 config, 1 delay, 2 min, 3 max, 4 cyclic on, 5 cyclic off
	logic [31:0] cfg_q [dioc_pkg::NCH][6];
	logic [31:0] ocfg_q [2];
	logic [14:0] tmr_on_q, tmr_off_q;
	logic [dioc_pkg::NCH-1:0] cond;
	logic tmr_state_q;
	// a write lands on the access-phase edge; refused addresses hit no register
	wire wr_en = psel & penable & pwrite;
	wire [2:0] ch_idx = 3'(paddr[11:5]);
	wire [2:0] ch_word = paddr[4:2];
	wire ch_hit = (paddr < 12'(dioc_pkg::NCH * 32)) && (ch_word < 3'd6) && (paddr[1:0] == 2'b00);
	wire top_hit = (paddr >= dioc_pkg::OUT0_CFG) && (paddr <= dioc_pkg::STATUS)
		&& (paddr[1:0] == 2'b00);

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			for (int c = 0; c < dioc_pkg::NCH; c++)
				for (int w = 0; w < 6; w++)
					cfg_q[c][w] <= (w == 0) ? dioc_pkg::CF_RST : dioc_pkg::ZERO_RST;
			ocfg_q[0] <= dioc_pkg::ZERO_RST;
			ocfg_q[1] <= dioc_pkg::ZERO_RST;
			tmr_on_q <= 15'h0000;
			tmr_off_q <= 15'h0000;
		end
		else if (wr_en)
		begin
			// timing words keep 15 bits only, so 0..32767
			if (ch_hit)
				cfg_q[ch_idx][ch_word] <= (ch_word == 3'd0) ? pwdata : {17'h0_0000, pwdata[14:0]};
			case (paddr)
				dioc_pkg::OUT0_CFG: ocfg_q[0] <= {13'h0000, pwdata[18:0]};
				dioc_pkg::OUT1_CFG: ocfg_q[1] <= {13'h0000, pwdata[18:0]};
				dioc_pkg::TMR_ON: tmr_on_q <= pwdata[14:0];
				dioc_pkg::TMR_OFF: tmr_off_q <= pwdata[14:0];
				default: ;
			endcase
		end

	// read mux, zero wait states; unmapped addresses flag pslverr
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (ch_hit)
			rd_mux = cfg_q[ch_idx][ch_word];
		else
			case (paddr)
				dioc_pkg::OUT0_CFG: rd_mux = ocfg_q[0];
				dioc_pkg::OUT1_CFG: rd_mux = ocfg_q[1];
				dioc_pkg::TMR_ON: rd_mux = {17'h0_0000, tmr_on_q};
				dioc_pkg::TMR_OFF: rd_mux = {17'h0_0000, tmr_off_q};
				dioc_pkg::STATUS: rd_mux = {24'h00_0000, relay_out, tmr_state_q, cond};
				default: rd_mux = 32'h0000_0000;
			endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(ch_hit | top_hit);
	assign prdata = rd_mux;

	////////////////////////////////////////////////////////////////////////////
	// free running cyclic timer
	// a zero on or off time flips the state on every tick
	logic [14:0] tcnt_q;
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			tcnt_q <= 15'h0000;
			tmr_state_q <= 1'b0;
		end
		else if (tick_q)
		begin
			if (tmr_state_q ? (tcnt_q + 15'h0001 >= tmr_on_q) : (tcnt_q + 15'h0001 >= tmr_off_q))
			begin
				tmr_state_q <= ~tmr_state_q;
				tcnt_q <= 15'h0000;
			end
			else
				tcnt_q <= tcnt_q + 15'h0001;
		end

	////////////////////////////////////////////////////////////////////////////
	// trigger sources: 0..4 channels, 5 timer, 6/7 raw pins
	logic [7:0] trig_src;
	assign trig_src = {disc_in[0], pkg_detect_in, tmr_state_q, cond};

	// conditioning chain per channel
	// input timers read flopped conditioned outputs, so a self-select makes no loop
	logic [dioc_pkg::NCH-1:0] raw;
	assign raw[0] = pkg_detect_in;
	assign raw[1] = disc_in[0];
	assign raw[2] = disc_in[1];
	assign raw[3] = trig_src[cfg_q[3][0][dioc_pkg::CF_SRC +: 3]];
	assign raw[4] = trig_src[cfg_q[4][0][dioc_pkg::CF_SRC +: 3]];

	logic [dioc_pkg::NCH-1:0] pol_v, deb_q, dly_q, lim_q, cyc_q;
	logic [14:0] dcnt_q [dioc_pkg::NCH];
	logic [14:0] ycnt_q [dioc_pkg::NCH];
	logic [14:0] lcnt_q [dioc_pkg::NCH];
	logic [14:0] ccnt_q [dioc_pkg::NCH];
	dioc_lim_t lst_q [dioc_pkg::NCH];

	for (genvar g = 0; g < dioc_pkg::NCH; g++)
	begin : g_ch
		wire [31:0] cf = cfg_q[g][0];
		wire [14:0] t_dly = cfg_q[g][1][14:0];
		wire [14:0] t_min = cfg_q[g][2][14:0];
		wire [14:0] t_max = cfg_q[g][3][14:0];
		wire [14:0] t_con = cfg_q[g][4][14:0];
		wire [14:0] t_coff = cfg_q[g][5][14:0];
		// polarity first, order fixed through the chain
		assign pol_v[g] = cf[dioc_pkg::CF_POL] ? raw[g] : ~raw[g];
		// deb_in high bypasses the filter and passes the level in one clock
		wire deb_in = cf[dioc_pkg::CF_DEB] ? 1'b0 : 1'b1;
		// debounce: new level must persist 15 ticks
		always_ff @(posedge clk_sys or posedge reset)
			if (reset)
			begin
				deb_q[g] <= 1'b0;
				dcnt_q[g] <= 15'h0000;
			end
			else if (pol_v[g] == deb_q[g])
				dcnt_q[g] <= 15'h0000;
			else if (deb_in)
				deb_q[g] <= pol_v[g];
			else if (tick_q)
			begin
				if (dcnt_q[g] + 15'h0001 >= dioc_pkg::DEB_TICKS)
				begin
					deb_q[g] <= pol_v[g];
					dcnt_q[g] <= 15'h0000;
				end
				else
					dcnt_q[g] <= dcnt_q[g] + 15'h0001;
			end
		// on/off delay: keep old state for delay after change
		// a zero delay passes the new level on the next clock
		always_ff @(posedge clk_sys or posedge reset)
			if (reset)
			begin
				dly_q[g] <= 1'b0;
				ycnt_q[g] <= 15'h0000;
			end
			else if (deb_q[g] == dly_q[g])
				ycnt_q[g] <= 15'h0000;
			else if (t_dly == 15'h0000)
				dly_q[g] <= deb_q[g];
			else if (tick_q)
			begin
				if (ycnt_q[g] + 15'h0001 >= t_dly)
				begin
					dly_q[g] <= deb_q[g];
					ycnt_q[g] <= 15'h0000;
				end
				else
					ycnt_q[g] <= ycnt_q[g] + 15'h0001;
			end
		// min/max limits; max zero means no limit
		// the counter saturates so a held input never wraps into a false max
		wire at_min = (lcnt_q[g] >= t_min);
		wire at_max = (t_max != 15'h0000) && (lcnt_q[g] >= t_max);
		always_ff @(posedge clk_sys or posedge reset)
			if (reset)
			begin
				lst_q[g] <= DIOC_IDLE;
				lim_q[g] <= 1'b0;
				lcnt_q[g] <= 15'h0000;
			end
			else
			begin
				if (tick_q && lst_q[g] != DIOC_IDLE && lcnt_q[g] != 15'h7FFF)
					lcnt_q[g] <= lcnt_q[g] + 15'h0001;
				case (lst_q[g])
					DIOC_IDLE:
						if (dly_q[g])
						begin
							lst_q[g] <= DIOC_MIN;
							lim_q[g] <= 1'b1;
							lcnt_q[g] <= 15'h0000;
						end
					DIOC_MIN:
						if (at_max)
						begin
							lst_q[g] <= DIOC_HOLD;
							lim_q[g] <= 1'b0;
						end
						else if (at_min)
							lst_q[g] <= DIOC_RUN;
					DIOC_RUN:
						if (!dly_q[g])
						begin
							lst_q[g] <= DIOC_IDLE;
							lim_q[g] <= 1'b0;
						end
						else if (at_max)
						begin
							lst_q[g] <= DIOC_HOLD;
							lim_q[g] <= 1'b0;
						end
					DIOC_HOLD:
						if (!dly_q[g])
							lst_q[g] <= DIOC_IDLE;
					default:
					begin
						lst_q[g] <= DIOC_IDLE;
						lim_q[g] <= 1'b0;
					end
				endcase
			end
		// cyclic pulsing only while limited signal active
		// a zero cyclic time toggles every tick, the fastest the grid allows
		always_ff @(posedge clk_sys or posedge reset)
			if (reset)
			begin
				cyc_q[g] <= 1'b0;
				ccnt_q[g] <= 15'h0000;
			end
			else if (!lim_q[g] || !cf[dioc_pkg::CF_CYC])
			begin
				cyc_q[g] <= lim_q[g];
				ccnt_q[g] <= 15'h0000;
			end
			else if (tick_q)
			begin
				if (ccnt_q[g] + 15'h0001 >= (cyc_q[g] ? t_con : t_coff))
				begin
					cyc_q[g] <= ~cyc_q[g];
					ccnt_q[g] <= 15'h0000;
				end
				else
					ccnt_q[g] <= ccnt_q[g] + 15'h0001;
			end
		assign cond[g] = cyc_q[g];
	end

	////////////////////////////////////////////////////////////////////////////
	// output contacts
	logic [1:0] oact_q;
	wire [1:0] relay_d;
	logic [1:0] relay_q;
	logic [14:0] ocnt_q [2];
	logic [1:0] otrg_prev_q;
	for (genvar o = 0; o < 2; o++)
	begin : g_out
		wire [14:0] t_on = ocfg_q[o][14:0];
		wire trg = trig_src[ocfg_q[o][dioc_pkg::OC_SEL +: 3]];
		// a retrigger while active restarts the on time
		wire rise = trg & ~otrg_prev_q[o];
		always_ff @(posedge clk_sys or posedge reset)
			if (reset)
			begin
				oact_q[o] <= 1'b0;
				ocnt_q[o] <= 15'h0000;
				otrg_prev_q[o] <= 1'b0;
			end
			else
			begin
				otrg_prev_q[o] <= trg;
				if (t_on == 15'h0000)
					oact_q[o] <= trg;
				else if (rise)
				begin
					oact_q[o] <= 1'b1;
					ocnt_q[o] <= 15'h0000;
				end
				else if (oact_q[o] && tick_q)
				begin
					if (ocnt_q[o] + 15'h0001 >= t_on)
						oact_q[o] <= 1'b0;
					else
						ocnt_q[o] <= ocnt_q[o] + 15'h0001;
				end
			end
		// contact closed when active xor normally closed
		assign relay_d[o] = oact_q[o] ^ ocfg_q[o][dioc_pkg::OC_NC];
	end

	// contacts come from a flop so an idle-state write cannot glitch the pin
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			relay_q <= 2'b00;
		else
			relay_q <= relay_d;
	assign relay_out = relay_q;
endmodule
